// ---- tb_trd_digitizer.sv ----
// Self-checking testbench for the tape read channel digitizer.
// Assumes trd_pkg, the digitizer and the controller model are compiled first.
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_fail++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end

module tb_trd_digitizer import trd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys_i = 1'b0;
   logic              reset_n_i = 1'b0;
   logic [4:0]        ev        = 5'h00;  // Peak, pos, neg, clear, error.
   logic [7:0]        lv        = 8'h00;  // Sel, online, test, busy, start, dreq, rev, gap.
   logic [ADDR_W-1:0] reg_addr  = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [DATA_W-1:0] st;
   logic              char_present_n_o, read_data_n_o, read_hd_o, read_valid_o, read_ready;
   logic [6:0]        thresh_pct_o;
   logic [15:0]       n_acc;
   logic [31:0]       lfsr = 32'hb884706f;
   logic              hold = 1'b0;
   logic              stall = 1'b1;
   int                n_fail = 0;
   int                checked = 0;
   int                n_exp = 0;
   int                exp_q[$];
   int                w;
   int                cases[4] = '{8'h0b, 8'h13, 8'h02, 8'h23};

   always #5 clk_sys_i = ~clk_sys_i;

   trd_digitizer u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ld_peak_i(ev[0]),
      .hd_pos_trans_i(ev[1]), .hd_neg_trans_i(ev[2]), .read_reg_clear_i(ev[3]),
      .selected_i(lv[0]), .on_line_i(lv[1]), .test_mode_i(lv[2]), .busy_i(lv[3]),
      .at_tape_start_i(lv[4]), .density_request_i(lv[5]),
      .reverse_high_density_read_i(lv[6]), .in_gap_i(lv[7]), .read_error_i(ev[4]),
      .char_present_n_o(char_present_n_o), .thresh_pct_o(thresh_pct_o),
      .read_data_n_o(read_data_n_o), .read_hd_o(read_hd_o), .read_valid_o(read_valid_o),
      .read_ready_i(read_ready), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

   trd_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .stall_i(stall),
      .read_valid_i(read_valid_o), .read_ready_o(read_ready), .accepted_o(n_acc));

   // =========================================================================
   // Random stalls and the word model
   // =========================================================================
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Stall pattern comes from the shift register so backpressure is irregular.
   always @(posedge clk_sys_i) begin
      lfsr  <= lfsr_next(lfsr);
      stall <= hold | lfsr[0];
   end

   // Every accepted word is checked against the head of the expected queue.
   always @(posedge clk_sys_i) begin
      if (reset_n_i && read_valid_o === 1'b1 && read_ready === 1'b1) begin
         w = (exp_q.size() == 0) ? 9 : exp_q.pop_front();
         `CHK("word", w, {read_hd_o, read_data_n_o})
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic push(input int v);
      exp_q.push_back(v);
      n_exp++;
   endtask

   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys_i);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr    <= 1'b0;
      tick(4);
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic reg_read(input logic [ADDR_W-1:0] a);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd   <= 1'b0;
      #1;
      st = reg_rdata;
   endtask

   // Pulses last two clocks so the input synchronisers cannot miss them.
   task automatic pulse(input int k);
      @(posedge clk_sys_i);
      ev[k] <= 1'b1;
      tick(2);
      ev[k] <= 1'b0;
      tick(6);
   endtask

   task automatic set_lv(input logic [7:0] v);
      @(posedge clk_sys_i);
      lv <= v;
      tick(6);
   endtask

   task automatic drain();
      for (int i = 0; i < 600 && exp_q.size() != 0; i++) tick(1);
      `CHK("queue left", 0, exp_q.size())
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk_sys_i);
      n_fail++;
      summarize();
   end

   // =========================================================================
   // Main sequence
   // =========================================================================
   initial begin
      tick(3);
      reset_n_i <= 1'b1;
      `CHK("char reset", 1'b1, char_present_n_o)
      `CHK("thresh reset", 7'd20, thresh_pct_o)
      `CHK("valid reset", 1'b0, read_valid_o)
      set_lv(8'h03);
      reg_read(OFF_STATUS);
      `CHK("ld enable", 1'b1, st[ST_LD_EN])
      reg_read(4'h8);
      `CHK("unmapped", 32'h0, st)
      pulse(0);
      `CHK("char set", 1'b0, char_present_n_o)
      push(0);
      pulse(3);
      `CHK("char cleared", 1'b1, char_present_n_o)
      push(1);
      pulse(3);
      drain();
      reg_write(OFF_CTRL, 32'h1);
      `CHK("thresh raw", 7'd33, thresh_pct_o)
      set_lv(8'h83);
      `CHK("thresh raw gap", 7'd40, thresh_pct_o)
      reg_write(OFF_CTRL, 32'h0);
      `CHK("thresh ro gap", 7'd27, thresh_pct_o)
      set_lv(8'h03);
      pulse(4);
      `CHK("thresh lowered", 7'd15, thresh_pct_o)
      pulse(4);
      `CHK("thresh raised", 7'd25, thresh_pct_o)
      pulse(4);
      `CHK("thresh held", 7'd25, thresh_pct_o)
      reg_write(OFF_CTRL, 32'h2);
      `CHK("thresh normal", 7'd20, thresh_pct_o)
      for (int k = 0; k < 4; k++) begin
         set_lv(8'h03);
         pulse(0);
         `CHK("char auto set", 1'b0, char_present_n_o)
         set_lv(cases[k][7:0]);
         `CHK("char auto clear", 1'b1, char_present_n_o)
         // With the low-density path disabled a held character must read as zero.
         if (k < 3) begin
            pulse(0);
            push(1);
            pulse(3);
         end
      end
      reg_read(OFF_STATUS);
      `CHK("hd enable", 1'b1, st[ST_HD_EN])
      `CHK("ld blocked", 1'b0, st[ST_LD_EN])
      push(2);
      pulse(1);
      pulse(2);
      set_lv(8'h63);
      push(2);
      pulse(2);
      pulse(1);
      pulse(0);
      pulse(3);
      tick(10);
      drain();
      set_lv(8'h27);
      reg_read(OFF_STATUS);
      `CHK("hd test mode", 1'b0, st[ST_HD_EN])
      set_lv(8'h23);
      hold <= 1'b1;
      tick(3);
      for (int i = 0; i < 20; i++) begin
         if (i < 17) push(2);
         pulse(1);
      end
      reg_read(OFF_STATUS);
      `CHK("overflow", 1'b1, st[ST_OVF])
      `CHK("fifo count", 5'd16, st[ST_CNT+:5])
      hold <= 1'b0;
      drain();
      reg_write(OFF_STATUS, 32'h8);
      reg_read(OFF_STATUS);
      `CHK("overflow clear", 1'b0, st[ST_OVF])
      tick(20);
      `CHK("accepted", n_exp[15:0], n_acc)
      summarize();
   end
endmodule

`default_nettype wire

// ---- trd_ctrl_model.sv ----
// Tape controller model: accepts read words from the digitizer's output stream.
// Assumes one clock shared with the digitizer; the bench steers stalls.
`default_nettype none

// =============================================================================
// Controller sink
// =============================================================================
module trd_ctrl_model (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        stall_i,
   input  wire logic        read_valid_i,
   output var  logic        read_ready_o,
   output var  logic [15:0] accepted_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Ready is registered, so a stall shows one cycle late, just as a real controller would.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         read_ready_o <= 1'b0;
         accepted_o   <= 16'h0000;
      end else begin
         read_ready_o <= !stall_i;
         if (read_valid_i && read_ready_o) begin
            accepted_o <= accepted_o + 16'h0001;
         end
      end
   end
endmodule

`default_nettype wire

// ---- trd_digitizer.sv ----
// Tape read channel digitizer: FIFO module and the channel top module.
// Assumes analog front end pulses arrive asynchronously and the tape
// controller drains read data with a valid/ready handshake.
//
// The strobed register port and the address map were left to the implementer.
`default_nettype none

// =============================================================================
// Synchronous FIFO
// =============================================================================
module trd_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   input  wire logic                       clk_sys_i,
   input  wire logic                       reset_n_i,
   input  wire logic                       in_valid_i,
   output logic                            in_ready_o,
   input  wire logic [WIDTH-1:0]           in_data_i,
   output logic                            out_valid_o,
   input  wire logic                       out_ready_i,
   output logic [WIDTH-1:0]                out_data_o,
   output logic [$clog2(DEPTH+1)-1:0]      count_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0]           mem [DEPTH];
   logic [AW-1:0]              wr_ptr;
   logic [AW-1:0]              rd_ptr;
   logic [$clog2(DEPTH+1)-1:0] count;
   wire                        push = in_valid_i && in_ready_o;
   wire                        pop  = out_valid_o && out_ready_i;

   // Full and empty come straight from the occupancy count.
   assign in_ready_o  = (count != $bits(count)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign count_o     = count;

   // Storage has no reset; only pointers and count carry control state.
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers wrap naturally because the depth is a power of two.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
         rd_ptr <= pop  ? rd_ptr + AW'(1) : rd_ptr;
         count  <= count + $bits(count)'(push) - $bits(count)'(pop);
      end
   end
endmodule

// =============================================================================
// Channel top
// =============================================================================
module trd_digitizer (
   input  wire logic                      clk_sys_i,
   input  wire logic                      reset_n_i,
   // Analog front end and density control, all asynchronous.
   input  wire logic                      ld_peak_i,
   input  wire logic                      hd_pos_trans_i,
   input  wire logic                      hd_neg_trans_i,
   input  wire logic                      read_reg_clear_i,
   input  wire logic                      selected_i,
   input  wire logic                      on_line_i,
   input  wire logic                      test_mode_i,
   input  wire logic                      busy_i,
   input  wire logic                      at_tape_start_i,
   input  wire logic                      density_request_i,
   input  wire logic                      reverse_high_density_read_i,
   input  wire logic                      in_gap_i,
   input  wire logic                      read_error_i,
   // Outputs toward density control, front end and tape controller, and the ready input back from the controller.
   output logic                           char_present_n_o,
   output logic [6:0]                     thresh_pct_o,
   output logic                           read_data_n_o,
   output logic                           read_hd_o,
   output logic                           read_valid_o,
   input  wire logic                      read_ready_i,
   // Register port.
   input  wire logic [trd_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [trd_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic [trd_pkg::DATA_W-1:0]     reg_rdata_o
);
   import trd_pkg::*;

   // Threshold for a given mode; retry only shifts read-only operation.
   function automatic logic [6:0] thresh_calc(input logic raw, input logic gap,
                                              input trd_retry_t rt);
      logic [6:0] base;
      base = raw ? THR_RAW_PCT : THR_RO_PCT;
      if (!raw && rt == RT_LOW) begin
         base = base - THR_RETRY_PCT;
      end else if (!raw && rt == RT_HIGH) begin
         base = base + THR_RETRY_PCT;
      end
      return gap ? base + THR_GAP_PCT : base;
   endfunction

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   logic [SY_N-1:0] sy_a;
   logic [SY_N-1:0] sy_b;
   logic [SY_N-1:0] sy_p;
   wire  [SY_N-1:0] raw_in = {read_error_i, in_gap_i, reverse_high_density_read_i,
                              density_request_i, at_tape_start_i, busy_i,
                              test_mode_i, on_line_i, selected_i, read_reg_clear_i,
                              hd_neg_trans_i, hd_pos_trans_i, ld_peak_i};

   // Two stages before any logic, a third copy only for edge detection.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         sy_a <= '0;
         sy_b <= '0;
         sy_p <= '0;
      end else begin
         sy_a <= raw_in;
         sy_b <= sy_a;
         sy_p <= sy_b;
      end
   end

   wire [SY_N-1:0] rise = sy_b & ~sy_p;
   wire [SY_N-1:0] fall = ~sy_b & sy_p;

   // ==========================================================================
   // Density selection and path enables
   // ==========================================================================
   wire hd_selected = sy_b[SY_DREQ] && sy_b[SY_SEL] && sy_b[SY_ONL] && !sy_b[SY_TEST];
   wire hd_en       = hd_selected && !sy_b[SY_BUSY] && !sy_b[SY_START];
   wire ld_en       = sy_b[SY_SEL] && !sy_b[SY_START] && !sy_b[SY_BUSY]
                      && !hd_en && !hd_selected;

   // ==========================================================================
   // Low-density read register
   // ==========================================================================
   logic read_reg;
   logic hd_sel_q;
   wire  peak      = rise[SY_LD_PEAK];
   // Deselect, busy, tape start and high-density selection all empty it.
   wire  auto_clr  = rise[SY_START] || rise[SY_BUSY] || fall[SY_SEL]
                     || (hd_selected && !hd_sel_q);
   wire  clr_any   = rise[SY_CLR] || auto_clr;
   // A peak landing on the clear cycle is kept: set beats clear.
   wire  next_reg  = peak ? 1'b1 : (clr_any ? 1'b0 : read_reg);

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         read_reg         <= 1'b0;
         char_present_n_o <= 1'b1;
         hd_sel_q         <= 1'b0;
      end else begin
         read_reg         <= next_reg;
         char_present_n_o <= !next_reg;
         hd_sel_q         <= hd_selected;
      end
   end

   // ==========================================================================
   // High-density transition path
   // ==========================================================================
   wire rev       = sy_b[SY_REV];
   wire pos_pass  = rise[SY_HD_POS] && !rev;
   wire neg_pass  = rise[SY_HD_NEG] && rev;
   wire hd_strobe = hd_en && (pos_pass || neg_pass);

   // ==========================================================================
   // Data into the FIFO
   // ==========================================================================
   // One low-density character bit per clear from density control unless the
   // high-density path is enabled; data counts only while the low-density path is enabled.
   wire                 ld_push   = rise[SY_CLR] && !hd_en;
   wire                 ld_bit    = read_reg && ld_en;
   wire                 f_in_v    = hd_strobe || ld_push;
   wire [FIFO_W-1:0]    f_in_d    = hd_strobe ? 2'b11 : {1'b0, ld_bit};
   wire                 f_in_rdy;
   wire                 f_out_v;
   wire [FIFO_W-1:0]    f_out_d;
   wire [4:0]           f_count;
   // The output stage takes a new word whenever it is empty or accepted.
   wire                 f_out_rdy = !read_valid_o || read_ready_i;

   trd_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (f_in_v),
      .in_ready_o  (f_in_rdy),
      .in_data_i   (f_in_d),
      .out_valid_o (f_out_v),
      .out_ready_i (f_out_rdy),
      .out_data_o  (f_out_d),
      .count_o     (f_count)
   );

   // Registered output stage; data is low true toward the controller.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         read_valid_o  <= 1'b0;
         read_data_n_o <= 1'b1;
         read_hd_o     <= 1'b0;
      end else if (f_out_rdy) begin
         read_valid_o  <= f_out_v;
         read_data_n_o <= f_out_v ? !f_out_d[0] : 1'b1;
         read_hd_o     <= f_out_v && f_out_d[1];
      end
   end

   // ==========================================================================
   // Register port decode
   // ==========================================================================
   logic       raw_mode;
   logic       overflow;
   trd_retry_t retry;
   wire        wr_ctrl  = reg_wr_i && reg_addr_i == OFF_CTRL;
   wire        wr_stat  = reg_wr_i && reg_addr_i == OFF_STATUS;
   wire [31:0] stat_w   = {11'h0, f_count, 1'b0, thresh_pct_o, 2'b0, retry,
                           overflow, hd_en, ld_en, read_reg};
   wire [31:0] rd_mux   = (reg_addr_i == OFF_CTRL)   ? {31'h0, raw_mode} :
                          (reg_addr_i == OFF_STATUS) ? stat_w : 32'h0;
   // A dropped sample is lost data, so it stays visible until cleared.
   wire        ovf_set  = f_in_v && !f_in_rdy;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         raw_mode    <= 1'b0;
         overflow    <= 1'b0;
         reg_rdata_o <= 32'h0;
      end else begin
         raw_mode    <= wr_ctrl ? reg_wdata_i[CTRL_RAW] : raw_mode;
         overflow    <= ovf_set || (overflow && !(wr_stat && reg_wdata_i[ST_OVF]));
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   // ==========================================================================
   // Retry sequencing and threshold select
   // ==========================================================================
   // An error first lowers the level, a repeat raises it; software restores.
   wire        err_ro    = rise[SY_ERR] && !raw_mode;
   trd_retry_t next_retry;
   assign next_retry = (wr_ctrl && reg_wdata_i[CTRL_RTCLR]) ? RT_NORMAL :
                       (err_ro && retry == RT_NORMAL)       ? RT_LOW :
                       (err_ro && retry == RT_LOW)          ? RT_HIGH : retry;
   // Update only with no character held and none arriving, so a decision
   // in progress never sees its reference move.
   wire        thr_upd   = !read_reg && !peak;
   wire [6:0]  next_thr  = thresh_calc(raw_mode, sy_b[SY_GAP], retry);

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         retry        <= RT_NORMAL;
         thresh_pct_o <= THR_RO_PCT;
      end else begin
         retry        <= next_retry;
         thresh_pct_o <= thr_upd ? next_thr : thresh_pct_o;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   a_peak_sets_reg: assert property (peak |=> read_reg && !char_present_n_o)
      else $error("peak did not set the read register");
   a_ld_bit_gated: assert property (ld_push && !ld_en |-> f_in_d == 2'b00)
      else $error("low density data passed while disabled");
   a_char_present: assert property (!peak && !clr_any |=> $stable(char_present_n_o))
      else $error("character present moved without a peak or a clear");
   a_clear_empties: assert property (clr_any && !peak |=> !read_reg && char_present_n_o
                                     ##1 read_reg == $past(peak))
      else $error("clear did not empty the register");
   a_busy_clears: assert property ($rose(sy_b[SY_BUSY]) && !peak |=> !read_reg)
      else $error("busy did not clear the register");
   a_paths_exclusive: assert property (hd_en |-> !ld_en)
      else $error("both density paths enabled");
   a_fwd_blocks_neg: assert property (!rev && !rise[SY_HD_POS] |-> !hd_strobe)
      else $error("forward read passed a negative transition");
   a_rev_takes_neg: assert property (hd_en && rev && rise[SY_HD_NEG] |-> hd_strobe)
      else $error("reverse read missed a negative transition");
   a_strobe_pushes: assert property (hd_strobe |-> f_in_v && f_in_d == 2'b11)
      else $error("high density transition not sent to the output path");
   a_thresh_ro: assert property (thr_upd && !raw_mode && !sy_b[SY_GAP]
                                 && retry == RT_NORMAL |=> thresh_pct_o == 7'd20)
      else $error("read-only threshold wrong");
   a_thresh_gap: assert property (thr_upd && raw_mode && sy_b[SY_GAP]
                                  |=> thresh_pct_o == 7'd40)
      else $error("gap threshold wrong");
   a_retry_raises: assert property (retry == RT_LOW && err_ro && !wr_ctrl
                                    |=> retry == RT_HIGH)
      else $error("repeated error did not raise thresholds");
   a_hd_needs_online: assert property (hd_en |-> sy_b[SY_ONL] && !sy_b[SY_START])
      else $error("high density enabled without its conditions");
   a_thresh_steady: assert property (read_reg |=> $stable(thresh_pct_o))
      else $error("threshold moved during a character");

   c_hd_reverse: cover property (hd_en && rev && hd_strobe);
   c_ld_char: cover property (ld_push && ld_bit);
   c_retry_high: cover property (retry == RT_HIGH);
   c_fifo_full: cover property (!f_in_rdy);
endmodule

`default_nettype wire

// ---- trd_pkg.sv ----
// Constants shared by the tape read channel digitizer and its FIFO.
// Assumes a single 100 MHz system clock and a plain register port.
`default_nettype none

package trd_pkg;

   // ==========================================================================
   // Register port layout
   // ==========================================================================
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 32;
   localparam logic [3:0]  OFF_CTRL    = 4'h0;  // Control, read/write.
   localparam logic [3:0]  OFF_STATUS  = 4'h4;  // Status, read, write one to clear.
   localparam int          CTRL_RAW    = 0;     // Read-after-write operation.
   localparam int          CTRL_RTCLR  = 1;     // Write one: retry back to normal.
   localparam int          ST_REG      = 0;
   localparam int          ST_LD_EN    = 1;
   localparam int          ST_HD_EN    = 2;
   localparam int          ST_OVF      = 3;
   localparam int          ST_RETRY    = 4;     // Two bits.
   localparam int          ST_THR      = 8;     // Seven bits.
   localparam int          ST_CNT      = 16;    // Five bits.

   // ==========================================================================
   // Synchronised input vector positions
   // ==========================================================================
   localparam int SY_LD_PEAK = 0;
   localparam int SY_HD_POS  = 1;
   localparam int SY_HD_NEG  = 2;
   localparam int SY_CLR     = 3;
   localparam int SY_SEL     = 4;
   localparam int SY_ONL     = 5;
   localparam int SY_TEST    = 6;
   localparam int SY_BUSY    = 7;
   localparam int SY_START   = 8;
   localparam int SY_DREQ    = 9;
   localparam int SY_REV     = 10;
   localparam int SY_GAP     = 11;
   localparam int SY_ERR     = 12;
   localparam int SY_N       = 13;

   // ==========================================================================
   // Detection thresholds, percent of peak-to-peak amplitude
   // ==========================================================================
   localparam logic [6:0] THR_RO_PCT    = 7'd20;
   localparam logic [6:0] THR_RAW_PCT   = 7'd33;
   localparam logic [6:0] THR_GAP_PCT   = 7'd7;
   localparam logic [6:0] THR_RETRY_PCT = 7'd5;  // Plain default step.

   // ==========================================================================
   // Data FIFO
   // ==========================================================================
   localparam int FIFO_W = 2;   // Bit 1 high-density flag, bit 0 data.
   localparam int FIFO_D = 16;

   typedef enum logic [1:0] {
      RT_NORMAL,
      RT_LOW,
      RT_HIGH
   } trd_retry_t;

endpackage

`default_nettype wire
